// >>> msj_pkg.sv
// Shared constants and types for the multi-speed and jog selector
package msj_pkg;
  localparam int FREQ_W    = 16;
  localparam int NUM_SLOTS = 16;
  localparam int IDX_W     = 4;
  localparam int NUM_TERMS = 7;
  localparam int FUNC_W    = 8;
  localparam int TSEL_W    = 3;
  // Frequencies in units of 0.01 Hz
  localparam logic [FREQ_W-1:0] JOG_FREQ_MAX   = 16'h03e7;
  localparam logic [FREQ_W-1:0] FREQ_MAX_RESET = 16'h1388;
  // Terminal function codes
  localparam logic [FUNC_W-1:0] FN_FWD  = 8'h00;
  localparam logic [FUNC_W-1:0] FN_REV  = 8'h01;
  localparam logic [FUNC_W-1:0] FN_SEL0 = 8'h02;
  localparam logic [FUNC_W-1:0] FN_JOG  = 8'h06;
  localparam logic [FUNC_W-1:0] FN_NONE = 8'hff;
  localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;
  localparam logic [2:0] JOG_STOP_FIRST_INVALID = 3'h3;
  localparam logic [2:0] JOG_STOP_LAST  = 3'h5;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FREQ_SET  = 8'h04;
  localparam logic [7:0] REG_JOG_FREQ  = 8'h08;
  localparam logic [7:0] REG_START_F   = 8'h0c;
  localparam logic [7:0] REG_MAX_F     = 8'h10;
  localparam logic [7:0] REG_EDIT      = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_OUT_FREQ  = 8'h1c;
  localparam logic [7:0] REG_TERM_LO   = 8'h20;
  localparam logic [7:0] REG_TERM_HI   = 8'h24;
  localparam logic [7:0] REG_SLOT_BASE = 8'h40;
  // Control register fields
  localparam int CTRL_RUN_SRC_LSB  = 0;
  localparam int CTRL_STOP_MODE_LSB = 4;
  localparam int CTRL_STORE_BIT    = 8;
  localparam int CTRL_KEY_RUN_BIT  = 9;
  typedef enum logic [1:0] {
    MSJ_STOP = 2'b00,
    MSJ_RUN  = 2'b01,
    MSJ_JOG  = 2'b11
  } msj_state_t;
endpackage

// >>> msj_sync.sv
// Two-flop synchroniser for a bank of terminal inputs
`timescale 1ns/10ps
`default_nettype none
module msj_sync #(
  parameter int W = 7
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> msj_term_map.sv
// Maps terminal function codes onto decoded command signals
`timescale 1ns/10ps
`default_nettype none
module msj_term_map
  import msj_pkg::*;
(
  input  wire logic [msj_pkg::NUM_TERMS-1:0]             term_i,
  input  wire logic [msj_pkg::NUM_TERMS*msj_pkg::FUNC_W-1:0] func_i,
  output logic      [msj_pkg::IDX_W-1:0]                 speed_idx_o,
  output logic                                           jog_request_o,
  output logic                                           forward_run_input_o,
  output logic                                           reverse_run_input_o
);
  // True when a terminal carries the given function and is active
  function automatic logic term_has(input logic [NUM_TERMS-1:0] t,
                                    input logic [NUM_TERMS*FUNC_W-1:0] f,
                                    input logic [FUNC_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++) begin
      if (t[i] && f[i*FUNC_W +: FUNC_W] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  genvar b;
  generate
    for (b = 0; b < IDX_W; b++) begin : g_bit
      assign speed_idx_o[b] = term_has(term_i, func_i, FN_SEL0 + FUNC_W'(b));
    end
  endgenerate

  assign jog_request_o       = term_has(term_i, func_i, FN_JOG);
  assign forward_run_input_o = term_has(term_i, func_i, FN_FWD);
  assign reverse_run_input_o = term_has(term_i, func_i, FN_REV);
endmodule
`default_nettype wire

// >>> msj_selector.sv
// Multi-speed and jog frequency reference selector with Wishbone registers
`timescale 1ns/10ps
`default_nettype none
module msj_selector
  import msj_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [msj_pkg::NUM_TERMS-1:0] term_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic      [msj_pkg::FREQ_W-1:0]    freq_ref_o,
  output logic                               run_o,
  output logic                               reverse_o,
  output logic                               jog_active_o,
  output logic                               no_ramp_o,
  output logic      [1:0]                    stop_kind_o
);
  import msj_pkg::*;

  logic [NUM_TERMS-1:0]        term_sync;
  logic [IDX_W-1:0]            speed_idx;
  logic                        jog_request;
  logic                        forward_run_input;
  logic                        reverse_run_input;
  logic [FREQ_W-1:0]           slot_mem [NUM_SLOTS];
  logic [FREQ_W-1:0]           frequency_setting_param;
  logic [FREQ_W-1:0]           jog_frequency_param;
  logic [FREQ_W-1:0]           start_freq;
  logic [FREQ_W-1:0]           max_freq;
  logic [FREQ_W-1:0]           edit_value;
  logic [1:0]                  run_source_param;
  logic [2:0]                  jog_stop_mode_param;
  logic                        key_run;
  logic [NUM_TERMS*FUNC_W-1:0] term_func;
  msj_state_t                  state;
  msj_state_t                  next_state;
  logic [FREQ_W-1:0]           next_freq_ref;
  logic [FREQ_W-1:0]           sel_freq;
  logic [FREQ_W-1:0]           jog_freq_lim;
  logic                        run_cmd;
  logic                        jog_ok;
  logic                        wb_req;
  logic                        wr_en;
  logic                        store_pulse;

  msj_sync #(.W(NUM_TERMS)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (term_i),
    .sync_o  (term_sync)
  );

  msj_term_map u_map (
    .term_i              (term_sync),
    .func_i              (term_func),
    .speed_idx_o         (speed_idx),
    .jog_request_o       (jog_request),
    .forward_run_input_o (forward_run_input),
    .reverse_run_input_o (reverse_run_input)
  );

  function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W-1:0] v,
                                              input logic [FREQ_W-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic [FREQ_W-1:0] merge(input logic [FREQ_W-1:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] sel);
    logic [FREQ_W-1:0] r;
    r = old;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en  = wb_req && wb_we_i;
  // store only on explicit store action
  assign store_pulse = wr_en && wb_adr_i == REG_CTRL && wb_sel_i[1] &&
                       wb_dat_i[CTRL_STORE_BIT];

  // run direction; both active means stop
  // keypad run honoured only in terminal mode
  assign run_cmd = (forward_run_input ^ reverse_run_input) ||
                   (key_run && run_source_param == RUN_SRC_TERMINAL);

  assign jog_freq_lim = clamp(jog_frequency_param, JOG_FREQ_MAX);
  // jog suppressed when zero or under start frequency
  assign jog_ok = jog_request && jog_freq_lim != '0 && jog_freq_lim >= start_freq;

  assign sel_freq = clamp((speed_idx == '0) ? frequency_setting_param
                                            : slot_mem[speed_idx], max_freq);

  // jog entry allowed during run only for modes 00..02
  always_comb begin
    next_state = state;
    case (state)
      MSJ_STOP: begin
        if (run_cmd && jog_ok) begin
          next_state = MSJ_JOG;
        end else if (run_cmd) begin
          next_state = MSJ_RUN;
        end
      end
      MSJ_RUN: begin
        if (!run_cmd) begin
          next_state = MSJ_STOP;
        end else if (jog_ok && jog_stop_mode_param < JOG_STOP_FIRST_INVALID) begin
          next_state = MSJ_JOG;
        end
      end
      MSJ_JOG: begin
        if (!run_cmd) begin
          next_state = MSJ_STOP;
        end else if (!jog_ok) begin
          next_state = MSJ_RUN;
        end
      end
      default: next_state = MSJ_STOP;
    endcase
  end

  // reference follows selection, jog with no ramp
  always_comb begin
    case (next_state)
      MSJ_JOG: next_freq_ref = jog_freq_lim;
      MSJ_RUN: next_freq_ref = sel_freq;
      default: next_freq_ref = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= MSJ_STOP;
      freq_ref_o   <= '0;
      run_o        <= 1'b0;
      reverse_o    <= 1'b0;
      jog_active_o <= 1'b0;
      no_ramp_o    <= 1'b0;
    end else begin
      state        <= next_state;
      freq_ref_o   <= next_freq_ref;
      run_o        <= next_state != MSJ_STOP;
      reverse_o    <= reverse_run_input && !forward_run_input;
      jog_active_o <= next_state == MSJ_JOG;
      no_ramp_o    <= next_state == MSJ_JOG;
    end
  end

  // stop kind: 0 free-run, 1 decelerate, 2 DC brake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_kind_o <= 2'h1;
    end else if (state == MSJ_JOG) begin
      stop_kind_o <= (jog_stop_mode_param >= JOG_STOP_FIRST_INVALID) ?
                     2'(jog_stop_mode_param - JOG_STOP_FIRST_INVALID) :
                     2'(jog_stop_mode_param);
    end else if (state == MSJ_RUN) begin
      stop_kind_o <= 2'h1;
    end
  end

  // slot storage; store only while stopped, into selected slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_mem[i] <= '0;
      end
    end else if (wr_en && wb_adr_i >= REG_SLOT_BASE &&
                 wb_adr_i < REG_SLOT_BASE + 8'(NUM_SLOTS * 4)) begin
      slot_mem[wb_adr_i[5:2]] <= merge(slot_mem[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
    end else if (store_pulse && state == MSJ_STOP && speed_idx != '0) begin
      slot_mem[speed_idx] <= edit_value;
    end
  end

  // Parameter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frequency_setting_param <= '0;
      jog_frequency_param     <= '0;
      start_freq              <= '0;
      max_freq                <= FREQ_MAX_RESET;
      edit_value              <= '0;
    end else if (wr_en) begin
      case (wb_adr_i)
        REG_FREQ_SET: frequency_setting_param <= merge(frequency_setting_param,
                                                       wb_dat_i, wb_sel_i);
        REG_JOG_FREQ: jog_frequency_param <= merge(jog_frequency_param, wb_dat_i, wb_sel_i);
        REG_START_F:  start_freq <= merge(start_freq, wb_dat_i, wb_sel_i);
        REG_MAX_F:    max_freq <= merge(max_freq, wb_dat_i, wb_sel_i);
        REG_EDIT:     edit_value <= merge(edit_value, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end else if (store_pulse && state == MSJ_STOP && speed_idx == '0) begin
      // index zero store never lands here: store_pulse implies wr_en, taken above
      frequency_setting_param <= edit_value;
    end
  end

  // Control register and terminal function map
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_source_param    <= RUN_SRC_TERMINAL;
      jog_stop_mode_param <= '0;
      key_run             <= 1'b0;
      for (int i = 0; i < NUM_TERMS; i++) begin
        term_func[i*FUNC_W +: FUNC_W] <= (i < 6) ? FUNC_W'(i) : FN_NONE;
      end
    end else if (wr_en) begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        run_source_param <= wb_dat_i[CTRL_RUN_SRC_LSB +: 2];
        if (wb_dat_i[CTRL_STOP_MODE_LSB +: 3] <= JOG_STOP_LAST) begin
          jog_stop_mode_param <= wb_dat_i[CTRL_STOP_MODE_LSB +: 3];
        end
      end
      if (wb_adr_i == REG_CTRL && wb_sel_i[1]) begin
        key_run <= wb_dat_i[CTRL_KEY_RUN_BIT];
      end
      if (wb_adr_i == REG_TERM_LO) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel_i[i]) term_func[i*FUNC_W +: FUNC_W] <= wb_dat_i[i*8 +: 8];
        end
      end
      if (wb_adr_i == REG_TERM_HI) begin
        for (int i = 0; i < 3; i++) begin
          if (wb_sel_i[i]) term_func[(i+4)*FUNC_W +: FUNC_W] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // Bus read and single-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= '0;
        if (wb_adr_i >= REG_SLOT_BASE && wb_adr_i < REG_SLOT_BASE + 8'(NUM_SLOTS * 4)) begin
          wb_dat_o <= {16'h0000, slot_mem[wb_adr_i[5:2]]};
        end else begin
          case (wb_adr_i)
            REG_CTRL:     wb_dat_o <= {22'h000000, key_run, 1'b0, 1'b0,
                                       jog_stop_mode_param, 2'h0, run_source_param};
            REG_FREQ_SET: wb_dat_o <= {16'h0000, frequency_setting_param};
            REG_JOG_FREQ: wb_dat_o <= {16'h0000, jog_frequency_param};
            REG_START_F:  wb_dat_o <= {16'h0000, start_freq};
            REG_MAX_F:    wb_dat_o <= {16'h0000, max_freq};
            REG_EDIT:     wb_dat_o <= {16'h0000, edit_value};
            // selected slot shown; output monitor beside it
            REG_STATUS:   wb_dat_o <= {sel_freq, 8'h00, 1'b0, state, jog_request,
                                       speed_idx};
            REG_OUT_FREQ: wb_dat_o <= {16'h0000, freq_ref_o};
            REG_TERM_LO:  wb_dat_o <= term_func[31:0];
            REG_TERM_HI:  wb_dat_o <= {8'h00, term_func[55:32]};
            default:      wb_dat_o <= '0;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> msj_switches.sv
// Terminal switch bank that drives the selector's input pins
`timescale 1ns/10ps
`default_nettype none
module msj_switches
  import msj_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic [msj_pkg::NUM_TERMS-1:0] want_i,
  output logic      [msj_pkg::NUM_TERMS-1:0] term_o
);
  // Contacts settle one edge after the operator moves them
  always_ff @(posedge clk_i) begin
    term_o <= want_i;
  end
endmodule
`default_nettype wire

// >>> msj_checker.sv
// Port-level checker for the multi-speed and jog selector
`timescale 1ns/10ps
`default_nettype none
module msj_checker
  import msj_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [msj_pkg::NUM_TERMS-1:0] term_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_ack_o,
  input  wire logic [msj_pkg::FREQ_W-1:0]    freq_ref_o,
  input  wire logic                          run_o,
  input  wire logic                          reverse_o,
  input  wire logic                          jog_active_o,
  input  wire logic                          no_ramp_o,
  input  wire logic [1:0]                    stop_kind_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet;
    ($stable(term_i) && !wb_cyc_i)[*5];
  endsequence
  a_ramp_bypass: assert property (no_ramp_o == jog_active_o)
    else $error("ramp bypass differs from jog state");
  a_jog_limit: assert property (jog_active_o |-> freq_ref_o <= JOG_FREQ_MAX)
    else $error("jog reference above jog ceiling");
  a_jog_running: assert property (jog_active_o |-> run_o)
    else $error("jog without run state");
  a_stop_legal: assert property (stop_kind_o != 2'h3)
    else $error("illegal stop kind");
  a_reset_state: assert property ($past(rst_i) |->
    !run_o && !jog_active_o && freq_ref_o == '0 && stop_kind_o == 2'h1)
    else $error("outputs not at reset state");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_term_quiet: assert property (s_quiet |->
    $stable({run_o, reverse_o, jog_active_o, stop_kind_o}))
    else $error("outputs moved without input change");
  c_jog: cover property (jog_active_o && freq_ref_o != '0);
  c_rev: cover property (run_o && reverse_o);
  c_bus: cover property (wb_ack_o ##1 !wb_ack_o);
endmodule
bind msj_selector msj_checker i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .term_i(term_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .freq_ref_o(freq_ref_o),
  .run_o(run_o), .reverse_o(reverse_o), .jog_active_o(jog_active_o),
  .no_ramp_o(no_ramp_o), .stop_kind_o(stop_kind_o)
);
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the multi-speed and jog selector
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import msj_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, run, rev, jog, nramp;
  logic [7:0]  adr;
  logic [31:0] dw, dr, rdat, e;
  logic [15:0] fref;
  logic [1:0]  skind;
  logic [6:0]  sw, term;
  int          fails, num_checks, cnt, i, m;
  msj_switches i_sw (.clk_i(clk_i), .want_i(sw), .term_o(term));
  msj_selector i_dut (.clk_i(clk_i), .rst_i(rst_i), .term_i(term), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .freq_ref_o(fref), .run_o(run), .reverse_o(rev),
    .jog_active_o(jog), .no_ramp_o(nramp), .stop_kind_o(skind));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cnt++;
    if (cnt > 30000) begin
      fails++;
      complete_run;
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dr;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, x, rdat);
  endtask
  task automatic setsw(input logic [6:0] v);
    @(posedge clk_i);
    sw <= v;
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dw = 32'h0; sw = 7'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("stop_kind", 32'h1, 32'(skind));
    rchk(REG_CTRL, 32'h1, "ctrl");
    rchk(REG_MAX_F, 32'h1388, "max_f");
    rchk(REG_TERM_LO, 32'h03020100, "term_lo");
    rchk(8'h3c, 32'h0, "unmapped");
    $display("test reset done");
    bus(1'b1, REG_FREQ_SET, 32'h0100);
    for (i = 1; i < 16; i++) bus(1'b1, REG_SLOT_BASE + 8'(4 * i), 32'h0200 + i);
    for (i = 0; i < 16; i++) begin
      setsw({1'b0, 4'(i), 2'b01});
      e = (i == 0) ? 32'h0100 : 32'h0200 + i;
      chk("freq_ref", e, 32'(fref));
      rchk(REG_OUT_FREQ, e, "out_freq");
    end
    chk("run_fwd", 32'h2, 32'({run, rev}));
    bus(1'b1, REG_SLOT_BASE + 8'h3c, 32'h2000);
    setsw(7'h3d);
    chk("clamped", 32'h1388, 32'(fref));
    bus(1'b1, REG_MAX_F, 32'h3000);
    setsw(7'h3d);
    chk("unclamped", 32'h2000, 32'(fref));
    bus(1'b1, REG_TERM_HI, 32'h0005ffff);
    setsw(7'h7d);
    chk("remapped", 32'h020b, 32'(fref));
    bus(1'b1, REG_TERM_HI, 32'h00ff0504);
    setsw(7'h02);
    chk("run_rev", 32'h3, 32'({run, rev}));
    setsw(7'h03);
    chk("both_stop", 32'h0, 32'(run));
    $display("test selection done");
    setsw(7'h0c);
    bus(1'b1, REG_EDIT, 32'h0333);
    rchk(REG_SLOT_BASE + 8'h0c, 32'h0203, "unstored");
    bus(1'b0, REG_STATUS, 32'h0);
    chk("display", 32'h0203, 32'(rdat[31:16]));
    bus(1'b1, REG_CTRL, 32'h101);
    rchk(REG_SLOT_BASE + 8'h0c, 32'h0333, "stored");
    setsw(7'h0d);
    chk("stored_ref", 32'h0333, 32'(fref));
    $display("test store done");
    bus(1'b1, REG_TERM_HI, 32'h00060504);
    bus(1'b1, REG_JOG_FREQ, 32'h0400);
    setsw(7'h41);
    chk("jog_clamp", 32'h103e7, {15'h0, jog, fref});
    chk("no_ramp", 32'h1, 32'(nramp));
    bus(1'b1, REG_JOG_FREQ, 32'h01f4);
    setsw(7'h41);
    chk("jog_ref", 32'h01f4, 32'(fref));
    for (m = 0; m < 6; m++) begin
      bus(1'b1, REG_CTRL, 32'h1 | (m << 4));
      setsw(7'h00);
      setsw(7'h41);
      chk("jog_stopped", 32'h1, 32'(jog));
      setsw(7'h00);
      chk("stop_kind", m % 3, 32'(skind));
      setsw(7'h01);
      setsw(7'h41);
      chk("jog_running", (m < 3) ? 32'h1 : 32'h0, 32'(jog));
    end
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_START_F, 32'h0200);
    setsw(7'h00);
    setsw(7'h41);
    chk("jog_below_start", 32'h0, 32'(jog));
    bus(1'b1, REG_START_F, 32'h0);
    bus(1'b1, REG_JOG_FREQ, 32'h0);
    setsw(7'h00);
    setsw(7'h41);
    chk("jog_zero", 32'h0, 32'(jog));
    bus(1'b1, REG_JOG_FREQ, 32'h01f4);
    setsw(7'h40);
    bus(1'b1, REG_CTRL, 32'h201);
    setsw(7'h40);
    chk("key_jog", 32'h1, 32'(jog));
    bus(1'b1, REG_CTRL, 32'h200);
    setsw(7'h40);
    chk("key_jog_off", 32'h0, 32'(jog));
    $display("test jog done");
    complete_run;
  end
endmodule
`default_nettype wire
